// ==== rtl/nfbi_pkg.sv ====
// Package of constants and carrier types for the flash bus controller
package nfbi_pkg;
   // Clock and timing
   localparam int CLK_MHZ = 125;
   localparam int STROBE_LOW_NS = 24;
   localparam int STROBE_HIGH_NS = 16;
   localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_SETTLE_NS = 100;
   localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_BUSY_MAX_US = 25;
   localparam int READ_BUSY_MAX_CYC = READ_BUSY_MAX_US * CLK_MHZ;
   localparam int PROG_BUSY_TYP_US = 200;
   localparam int ERASE_BUSY_TYP_US = 1500;
   localparam int BUSY_LIMIT_CYC = 20 * ERASE_BUSY_TYP_US * CLK_MHZ;
   localparam int CNT_W = 24;
   // Address layout
   localparam int COL_W = 12;
   localparam int ROW_W = 19;
   localparam int ADDR_W = 31;
   localparam int ROW_LSB = 12;
   localparam int ADDR_CYC_FULL = 5;
   localparam int ADDR_CYC_ROW = 3;
   localparam int PAGE_BYTES = 2112;
   localparam int LEN_W = 12;
   // Operation codes
   typedef enum logic [1:0] {NFBI_OP_READ, NFBI_OP_PROG, NFBI_OP_ERASE} nfbi_op_type;
   // Command request carrier
   typedef struct packed {
      nfbi_op_type op;
      logic die;
      logic [7:0] cmd1;
      logic [7:0] cmd2;
      logic [ADDR_W-1:0] addr;
      logic [LEN_W-1:0] len;
   } nfbi_req_type;
   // Completion status carrier
   typedef struct packed {
      logic timeout;
      logic protect;
   } nfbi_sts_type;
endpackage

// ==== rtl/nfbi_ctrl.sv ====
// Flash bus controller: FIFO and pin sequencer
`timescale 1ns/100ps

// Byte FIFO in flip-flops
module nfbi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
   logic [AW-1:0] wp_r, wp_nxt; // Write index
   logic [AW-1:0] rp_r, rp_nxt; // Read index
   logic [AW:0] cnt_r, cnt_nxt; // Fill level
   logic push, pop;
   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rp_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   // Next pointer values
   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end
   // Register pointers
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (clk_en_i) begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   // Storage write, no reset needed
   always_ff @(posedge sys_clk_i) begin
      if (clk_en_i && push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end
endmodule

// Sequencer driving the flash pins
module nfbi_ctrl
   import nfbi_pkg::*;
#(
   parameter int BUSY_LIMIT = BUSY_LIMIT_CYC,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire nfbi_req_type req_i,
   output logic done_o,
   output nfbi_sts_type sts_o,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [7:0] wr_data_i,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [7:0] rd_data_o,
   input wire logic wp_enable_i,
   output logic chip_sel_n_o,
   output logic second_die_sel_n_o,
   output logic cmd_latch_o,
   output logic addr_latch_o,
   output logic write_strobe_n_o,
   output logic read_strobe_n_o,
   output logic write_protect_n_o,
   input wire logic [7:0] data_io_i,
   output logic [7:0] data_io_o,
   output logic data_io_oe_n_o,
   input wire logic ready_busy_n_i
);
   typedef enum logic [3:0] {
      S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WAIT, S_BUSY, S_RDATA, S_DONE
   } nfbi_state_type;
   nfbi_state_type st_r, st_nxt; // Sequencer state
   nfbi_req_type rq_r, rq_nxt; // Latched request
   logic [7:0] dout_r, dout_nxt; // Pin byte out
   logic oe_n_r, oe_n_nxt; // Pin drive enable, low drives
   logic cle_r, cle_nxt; // Command latch pin
   logic ale_r, ale_nxt; // Address latch pin
   logic we_n_r, we_n_nxt; // Write strobe pin
   logic re_n_r, re_n_nxt; // Read strobe pin
   logic [1:0] ph_r, ph_nxt; // 0 setup,1 low,2 high
   logic [3:0] tc_r, tc_nxt; // Strobe phase timer
   logic [2:0] ac_r, ac_nxt; // Address cycle index
   logic [LEN_W-1:0] bc_r, bc_nxt; // Byte counter
   logic [CNT_W-1:0] wc_r, wc_nxt; // Busy wait counter
   logic done_r, done_nxt;
   nfbi_sts_type sts_r, sts_nxt;
   logic [7:0] rdq_data; // Byte into read FIFO
   logic rdq_push, rdq_ready; // Read FIFO fill side
   logic [7:0] wq_data; // Byte from write FIFO
   logic wq_valid, wq_pop; // Write FIFO drain side
   logic [7:0] abyte; // Current address byte
   logic [2:0] alast; // Last address cycle index
   logic [2:0] afirst; // First address cycle index
   logic strobe_end; // Strobe high phase done
   logic die_sel_n;
   // Address byte mux, unused high bits forced low
   always_comb begin
      case (ac_r)
         3'h0: abyte = rq_r.addr[7:0];
         3'h1: abyte = {4'h0, rq_r.addr[11:8]};
         3'h2: abyte = rq_r.addr[19:12];
         3'h3: abyte = rq_r.addr[27:20];
         3'h4: abyte = {5'h00, rq_r.addr[30:28]};
         default: abyte = 8'h00;
      endcase
   end
   // Erase sends only row cycles
   assign afirst = (rq_r.op == NFBI_OP_ERASE) ? 3'(ADDR_CYC_FULL - ADDR_CYC_ROW) : 3'h0;
   assign alast = 3'(ADDR_CYC_FULL - 1);
   assign strobe_end = (ph_r == 2'h2) && (tc_r == 4'(STROBE_HIGH_CYC - 1));
   assign die_sel_n = (st_r == S_IDLE) || (st_r == S_DONE);
   // Write FIFO between user and pins
   nfbi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wq (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
      .in_valid_i(wr_valid_i), .in_ready_o(wr_ready_o), .in_data_i(wr_data_i),
      .out_valid_o(wq_valid), .out_ready_i(wq_pop), .out_data_o(wq_data)
   );
   // Read FIFO, stalls read strobes when full
   nfbi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rq (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
      .in_valid_i(rdq_push), .in_ready_o(rdq_ready), .in_data_i(rdq_data),
      .out_valid_o(rd_valid_o), .out_ready_i(rd_ready_i), .out_data_o(rd_data_o)
   );
   assign req_ready_o = (st_r == S_IDLE);
   assign done_o = done_r;
   assign sts_o = sts_r;
   assign rdq_data = data_io_i;
   // Sample byte late in the read strobe low time
   assign rdq_push = (st_r == S_RDATA) && (ph_r == 2'h1)
                     && (tc_r == 4'(STROBE_LOW_CYC - 1));
   assign wq_pop = (st_r == S_WDATA) && strobe_end;
   // Pins; protect low unless program or erase allowed
   assign write_protect_n_o = wp_enable_i;
   assign chip_sel_n_o = die_sel_n || rq_r.die;
   assign second_die_sel_n_o = die_sel_n || !rq_r.die;
   assign cmd_latch_o = cle_r;
   assign addr_latch_o = ale_r;
   assign write_strobe_n_o = we_n_r;
   assign read_strobe_n_o = re_n_r;
   assign data_io_o = dout_r;
   assign data_io_oe_n_o = oe_n_r;
   // Sequencer next state
   always_comb begin
      st_nxt = st_r;
      rq_nxt = rq_r;
      dout_nxt = dout_r;
      oe_n_nxt = oe_n_r;
      cle_nxt = 1'b0;
      ale_nxt = 1'b0;
      we_n_nxt = 1'b1;
      re_n_nxt = 1'b1;
      ph_nxt = ph_r;
      tc_nxt = tc_r;
      ac_nxt = ac_r;
      bc_nxt = bc_r;
      wc_nxt = wc_r;
      done_nxt = 1'b0;
      sts_nxt = sts_r;
      // Strobe phase timing for write and read cycles
      if (st_r inside {S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_RDATA}) begin
         case (ph_r)
            2'h0: begin
               ph_nxt = 2'h1;
               tc_nxt = 4'h0;
            end
            2'h1: begin
               tc_nxt = tc_r + 4'h1;
               if (tc_r == 4'(STROBE_LOW_CYC - 1)) begin
                  ph_nxt = 2'h2;
                  tc_nxt = 4'h0;
               end
            end
            default: begin
               tc_nxt = tc_r + 4'h1;
               if (strobe_end) begin
                  ph_nxt = 2'h0;
               end
            end
         endcase
      end
      case (st_r)
         S_IDLE: begin
            oe_n_nxt = 1'b1;
            if (req_valid_i) begin
               rq_nxt = req_i;
               st_nxt = S_CMD1;
               ph_nxt = 2'h0;
               sts_nxt = '0;
            end
         end
         S_CMD1: begin
            cle_nxt = 1'b1;
            oe_n_nxt = 1'b0;
            dout_nxt = rq_r.cmd1;
            we_n_nxt = !(ph_r == 2'h1);
            if (strobe_end) begin
               st_nxt = S_ADDR;
               ac_nxt = afirst;
            end
         end
         S_ADDR: begin
            ale_nxt = 1'b1;
            dout_nxt = abyte;
            we_n_nxt = !(ph_r == 2'h1);
            if (strobe_end) begin
               ac_nxt = ac_r + 3'h1;
               if (ac_r == alast) begin
                  bc_nxt = rq_r.len;
                  st_nxt = (rq_r.op == NFBI_OP_PROG && rq_r.len != '0) ? S_WDATA : S_CMD2;
               end
            end
         end
         S_WDATA: begin
            // Hold off the strobe until a byte waits
            if (ph_r == 2'h0 && !wq_valid) begin
               ph_nxt = 2'h0;
            end else begin
               we_n_nxt = !(ph_r == 2'h1);
            end
            dout_nxt = wq_data;
            if (strobe_end) begin
               bc_nxt = bc_r - 1'b1;
               if (bc_r == LEN_W'(1)) begin
                  st_nxt = S_CMD2;
               end
            end
         end
         S_CMD2: begin
            cle_nxt = 1'b1;
            dout_nxt = rq_r.cmd2;
            we_n_nxt = !(ph_r == 2'h1);
            if (strobe_end) begin
               st_nxt = S_WAIT;
               wc_nxt = '0;
               oe_n_nxt = 1'b1;
            end
         end
         S_WAIT: begin
            // Let the busy line fall before watching it
            wc_nxt = wc_r + 1'b1;
            if (wc_r == CNT_W'(BUSY_SETTLE_CYC)) begin
               st_nxt = S_BUSY;
            end
         end
         S_BUSY: begin
            // Hold selected until ready returns or wc_r reaches BUSY_LIMIT
            wc_nxt = wc_r + 1'b1;
            if (ready_busy_n_i) begin
               if (!wp_enable_i && rq_r.op != NFBI_OP_READ) begin
                  sts_nxt.protect = 1'b1;
               end
               bc_nxt = rq_r.len;
               ph_nxt = 2'h0;
               st_nxt = (rq_r.op == NFBI_OP_READ && rq_r.len != '0) ? S_RDATA : S_DONE;
            end else if (wc_r == CNT_W'(BUSY_LIMIT)) begin
               sts_nxt.timeout = 1'b1;
               st_nxt = S_DONE;
            end
         end
         S_RDATA: begin
            // Stall strobes while the read FIFO is full
            if (ph_r == 2'h0 && !rdq_ready) begin
               ph_nxt = 2'h0;
            end else begin
               re_n_nxt = !(ph_r == 2'h1);
            end
            if (strobe_end) begin
               bc_nxt = bc_r - 1'b1;
               if (bc_r == LEN_W'(1)) begin
                  st_nxt = S_DONE;
               end
            end
         end
         S_DONE: begin
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
   end
   // Sequencer registers
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         st_r <= S_IDLE;
         rq_r <= '0;
         dout_r <= 8'h00;
         oe_n_r <= 1'b1;
         cle_r <= 1'b0;
         ale_r <= 1'b0;
         we_n_r <= 1'b1;
         re_n_r <= 1'b1;
         ph_r <= 2'h0;
         tc_r <= 4'h0;
         ac_r <= 3'h0;
         bc_r <= '0;
         wc_r <= '0;
         done_r <= 1'b0;
         sts_r <= '0;
      end else if (clk_en_i) begin
         st_r <= st_nxt;
         rq_r <= rq_nxt;
         dout_r <= dout_nxt;
         oe_n_r <= oe_n_nxt;
         cle_r <= cle_nxt;
         ale_r <= ale_nxt;
         we_n_r <= we_n_nxt;
         re_n_r <= re_n_nxt;
         ph_r <= ph_nxt;
         tc_r <= tc_nxt;
         ac_r <= ac_nxt;
         bc_r <= bc_nxt;
         wc_r <= wc_nxt;
         done_r <= done_nxt;
         sts_r <= sts_nxt;
      end
   end
endmodule

// ==== tb/nfbi_ctrl_asserts.sv ====
// Pin protocol checker for the flash sequencer
`timescale 1ns/100ps
module nfbi_ctrl_asserts (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic req_ready_o,
   input wire logic done_o,
   input wire logic chip_sel_n_o,
   input wire logic second_die_sel_n_o,
   input wire logic cmd_latch_o,
   input wire logic addr_latch_o,
   input wire logic write_strobe_n_o,
   input wire logic read_strobe_n_o,
   input wire logic [7:0] data_io_o,
   input wire logic data_io_oe_n_o
);
   // One clock, quiet in reset
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // Latches exclusive
   property p_latch; !(cmd_latch_o && addr_latch_o); endproperty
   a_latch: assert property (p_latch) else $error("both latches high");
   // Write pulse three cycles low
   property p_we_len; $fell(write_strobe_n_o) |-> !write_strobe_n_o [*3] ##1 write_strobe_n_o;
   endproperty
   a_we_len: assert property (p_we_len) else $error("write pulse length");
   // Byte, latches and drive steady under the pulse
   property p_we_hold;
      !write_strobe_n_o |-> !data_io_oe_n_o && $stable({data_io_o, cmd_latch_o, addr_latch_o});
   endproperty
   a_we_hold: assert property (p_we_hold) else $error("write byte moved");
   // Exactly one die selected under a strobe
   property p_die;
      !(write_strobe_n_o && read_strobe_n_o) |-> chip_sel_n_o != second_die_sel_n_o;
   endproperty
   a_die: assert property (p_die) else $error("die select");
   // Bus released while reading
   property p_rd; !read_strobe_n_o |-> data_io_oe_n_o && !cmd_latch_o && !addr_latch_o;
   endproperty
   a_rd: assert property (p_rd) else $error("bus driven in read");
   // Done lasts one cycle
   property p_done; done_o |=> !done_o; endproperty
   a_done: assert property (p_done) else $error("done too long");
   // Idle leaves the device deselected
   property p_idle; req_ready_o |-> chip_sel_n_o && second_die_sel_n_o && write_strobe_n_o;
   endproperty
   a_idle: assert property (p_idle) else $error("idle select");
   // No read soon after a command byte
   property p_gap; $rose(write_strobe_n_o) && $past(cmd_latch_o) |-> read_strobe_n_o [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("read too early");
   c_read: cover property ($fell(read_strobe_n_o));
   c_addr: cover property (addr_latch_o && !write_strobe_n_o);
   c_done: cover property (done_o);
endmodule
bind nfbi_ctrl nfbi_ctrl_asserts u_chk (.sys_clk_i, .resetn_i, .req_ready_o, .done_o,
   .chip_sel_n_o, .second_die_sel_n_o, .cmd_latch_o, .addr_latch_o, .write_strobe_n_o,
   .read_strobe_n_o, .data_io_o, .data_io_oe_n_o);

// ==== tb/nfbi_flash_model.sv ====
// Behavioural flash die driven by its pins
`timescale 1ns/100ps
module nfbi_flash_model #(
   parameter int BUSY_NS = 3000,
   parameter logic [7:0] C_PROG = 8'h80,
   parameter logic [7:0] C_ERASE = 8'h60
) (
   input wire logic ce_n_i,
   input wire logic cle_i,
   input wire logic ale_i,
   input wire logic we_n_i,
   input wire logic re_n_i,
   input wire logic wp_n_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o,
   output logic drv_o,
   output logic busy_o = 1'b0
);
   logic [7:0] mem[longint]; // Array by row and column
   logic [7:0] pg[0:2111]; // Page register
   logic [7:0] ab[0:4]; // Address bytes kept
   logic [7:0] cmd; // First command byte
   bit pend = 1'b0; // Second command awaited
   int n_ab = 0, col = 0, scol = 0, r; // Address count, column pointers, row
   // Drive only selected with read strobe low
   assign drv_o = !ce_n_i && !re_n_i;
   // Next byte out, column steps
   always @(negedge re_n_i) if (!ce_n_i) begin
      dq_o = pg[col];
      col++;
   end
   // Bytes taken on the strobe rise
   always @(posedge we_n_i) if (!ce_n_i) begin
      if (cle_i && !pend) begin
         cmd = dq_i;
         n_ab = 0;
         pend = 1'b1;
      end else if (cle_i) begin
         pend = 1'b0;
         r = (cmd == C_ERASE) ? {ab[2][2:0], ab[1], ab[0]} : {ab[4][2:0], ab[3], ab[2]};
         busy_o = 1'b1;
         if (cmd == C_PROG && wp_n_i) begin
            for (int c = scol; c < col; c++) mem[r * 4096 + c] = pg[c];
         end else if (cmd == C_ERASE && wp_n_i) begin
            foreach (mem[k]) if (k / 262144 == r / 64) mem[k] = 8'hFF;
         end else if (cmd != C_PROG && cmd != C_ERASE) begin
            for (int c = 0; c < 2112; c++) pg[c] = mem.exists(r*4096+c) ? mem[r*4096+c] : 8'hFF;
         end
         #(BUSY_NS) busy_o = 1'b0;
      end else if (ale_i) begin
         if (n_ab < ((cmd == C_ERASE) ? 3 : 5)) ab[n_ab] = dq_i;
         n_ab++;
         scol = {ab[1][3:0], ab[0]};
         col = scol;
      end else begin
         pg[col] = dq_i;
         col++;
      end
   end
endmodule

// ==== tb/nfbi_ctrl_tb.sv ====
// Self-checking bench for the flash pin sequencer
`timescale 1ns/100ps
module nfbi_ctrl_tb;
   import nfbi_pkg::*;
   logic sys_clk_i = 0, resetn_i = 0, req_valid_i = 0, wr_valid_i = 0, rd_ready_i = 0;
   logic wp_enable_i = 1, stuck = 0, hold = 0; // Write enable (protect pin high), stuck busy, read stall
   logic [7:0] wr_data_i = 8'h00, junk = 8'h00; // Write byte, floating bus pattern
   nfbi_req_type req_i = '0;
   nfbi_sts_type sts_o;
   logic req_ready_o, done_o, wr_ready_o, rd_valid_o, chip_sel_n_o, second_die_sel_n_o;
   logic cmd_latch_o, addr_latch_o, write_strobe_n_o, read_strobe_n_o, write_protect_n_o;
   logic data_io_oe_n_o, drv0, drv1, bsy0, bsy1, ready_busy_n_i, clk_en_i = 1;
   logic [7:0] rd_data_o, data_io_o, dq0, dq1, data_io_i;
   logic [7:0] wq[$], rq[$], ref_mem[longint]; // Pending writes, reads, expected array
   int mismatches = 0, n_compared = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   // Bus wire: a die, the controller, else a changing pattern
   assign data_io_i = drv0 ? dq0 : drv1 ? dq1 : !data_io_oe_n_o ? data_io_o : junk;
   assign ready_busy_n_i = !(bsy0 || bsy1 || stuck);
   always @(posedge sys_clk_i) junk <= junk + 8'h5B;
   nfbi_ctrl #(.BUSY_LIMIT(2000)) dut (.sys_clk_i, .resetn_i, .clk_en_i, .req_valid_i,
      .req_ready_o, .req_i, .done_o, .sts_o, .wr_valid_i, .wr_ready_o, .wr_data_i, .rd_valid_o,
      .rd_ready_i, .rd_data_o, .wp_enable_i, .chip_sel_n_o, .second_die_sel_n_o, .cmd_latch_o,
      .addr_latch_o, .write_strobe_n_o, .read_strobe_n_o, .write_protect_n_o, .data_io_i,
      .data_io_o, .data_io_oe_n_o, .ready_busy_n_i);
   nfbi_flash_model u_m0 (.ce_n_i(chip_sel_n_o), .cle_i(cmd_latch_o), .ale_i(addr_latch_o),
      .we_n_i(write_strobe_n_o), .re_n_i(read_strobe_n_o), .wp_n_i(write_protect_n_o),
      .dq_i(data_io_i), .dq_o(dq0), .drv_o(drv0), .busy_o(bsy0));
   nfbi_flash_model u_m1 (.ce_n_i(second_die_sel_n_o), .cle_i(cmd_latch_o), .ale_i(addr_latch_o),
      .we_n_i(write_strobe_n_o), .re_n_i(read_strobe_n_o), .wp_n_i(write_protect_n_o),
      .dq_i(data_io_i), .dq_o(dq1), .drv_o(drv1), .busy_o(bsy1));
   // Stream drivers at the falling edge
   always @(negedge sys_clk_i) begin
      wr_valid_i <= wq.size() != 0;
      if (wq.size() != 0) wr_data_i <= wq[0];
      rd_ready_i <= !hold && ($urandom % 4 != 0);
   end
   // Stream handshakes taken at the rising edge
   always @(posedge sys_clk_i) begin
      if (wr_valid_i && wr_ready_o) void'(wq.pop_front());
      if (rd_valid_o && rd_ready_i) rq.push_back(rd_data_o);
   end
   task automatic chk_b(logic [7:0] got, logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_s(nfbi_sts_type got, nfbi_sts_type exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %0t status %b expected %b", $time, got, exp);
      end
   endtask
   function automatic longint key(logic die, logic [30:0] a, int i);
      return longint'({die, a[30:12], a[11:0] + 12'(i)});
   endfunction
   function automatic logic [7:0] exp_b(logic die, logic [30:0] a, int i);
      return ref_mem.exists(key(die, a, i)) ? ref_mem[key(die, a, i)] : 8'hFF;
   endfunction
   // One operation: load, request, stall, finish, compare
   task automatic run(string name, nfbi_op_type op, logic die, logic [30:0] a, int n, bit st);
      int w;
      logic [7:0] b;
      logic [39:0] eab;
      eab = {5'h00, a[30:28], a[27:20], a[19:12], 4'h0, a[11:8], a[7:0]};
      if (op == NFBI_OP_ERASE) eab = {16'h0000, eab[39:16]};
      rq.delete();
      for (int i = 0; i < n && op == NFBI_OP_PROG; i++) begin
         b = 8'($urandom);
         wq.push_back(b);
         if (wp_enable_i) ref_mem[key(die, a, i)] = b;
      end
      if (op == NFBI_OP_ERASE && wp_enable_i)
         foreach (ref_mem[k]) if ((k >> 18) == {die, a[30:18]}) ref_mem[k] = 8'hFF;
      if (n > 16 && op == NFBI_OP_PROG) begin
         repeat (40) @(negedge sys_clk_i);
         chk_b({7'h00, wr_ready_o}, 8'h00);
         chk_b(8'(wq.size()), 8'(n - 16));
      end
      hold = st;
      @(negedge sys_clk_i);
      req_i = '{op: op, die: die, addr: a, len: 12'(n),
         cmd1: op == NFBI_OP_PROG ? 8'h80 : op == NFBI_OP_ERASE ? 8'h60 : 8'h00,
         cmd2: op == NFBI_OP_PROG ? 8'h10 : op == NFBI_OP_ERASE ? 8'hD0 : 8'h30};
      req_valid_i = 1'b1;
      @(posedge sys_clk_i);
      while (!req_ready_o) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      req_valid_i = 1'b0;
      if (st) begin
         repeat (800) @(negedge sys_clk_i);
         chk_b({rd_valid_o, done_o, 6'h00}, 8'h80);
         hold = 1'b0;
      end
      for (w = 0; w < 20000 && done_o !== 1'b1; w++) @(posedge sys_clk_i);
      // A lost done pulse counts as a failure
      if (w == 20000) begin
         mismatches++;
         $display("unexpected %0t no done pulse", $time);
      end
      chk_s(sts_o, '{timeout: stuck, protect: op != NFBI_OP_READ && !wp_enable_i});
      for (w = 0; w < 1000 && rq.size() < n && op == NFBI_OP_READ; w++) @(posedge sys_clk_i);
      if (op == NFBI_OP_READ) chk_b(8'(rq.size()), 8'(n));
      for (int i = 0; i < rq.size(); i++) chk_b(rq[i], exp_b(die, a, i));
      for (int k = 0; k < (op == NFBI_OP_ERASE ? 3 : 5); k++)
         chk_b(die ? u_m1.ab[k] : u_m0.ab[k], eab[8*k +: 8]);
      chk_b(8'(die ? u_m1.n_ab : u_m0.n_ab), op == NFBI_OP_ERASE ? 8'h03 : 8'h05);
      @(negedge sys_clk_i);
      $display("test %s done", name);
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog for a hung handshake
   initial begin
      #(500000);
      mismatches++;
      $display("unexpected %0t watchdog expired", $time);
      end_sim();
   end
   initial begin
      logic [30:0] a;
      logic [30:0] e;
      logic d;
      void'($urandom(41));
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      resetn_i = 1'b1;
      a = {19'h0ABCD, 12'h123};
      e = {19'h7FFFF, 12'h834};
      run("fill_program", NFBI_OP_PROG, 1'b0, a, 24, 1'b0);
      run("stalled_read", NFBI_OP_READ, 1'b0, a, 24, 1'b1);
      run("other_die", NFBI_OP_READ, 1'b1, a, 24, 1'b0);
      run("last_column", NFBI_OP_PROG, 1'b1, e, 12, 1'b0);
      run("last_column_read", NFBI_OP_READ, 1'b1, e, 12, 1'b0);
      run("erase", NFBI_OP_ERASE, 1'b0, a, 0, 1'b0);
      run("erased_read", NFBI_OP_READ, 1'b0, a, 24, 1'b0);
      wp_enable_i = 1'b0;
      run("protected_program", NFBI_OP_PROG, 1'b0, a, 8, 1'b0);
      run("protected_read", NFBI_OP_READ, 1'b0, a, 8, 1'b0);
      wp_enable_i = 1'b1;
      stuck = 1'b1;
      run("stuck_busy", NFBI_OP_READ, 1'b0, a, 0, 1'b0);
      stuck = 1'b0;
      repeat (4) begin
         a = {19'($urandom), 12'($urandom % 2048)};
         d = 1'($urandom);
         run("random_program", NFBI_OP_PROG, d, a, 1 + $urandom % 30, 1'b0);
         run("random_read", NFBI_OP_READ, d, a, 1 + $urandom % 30, 1'b0);
      end
      end_sim();
   end
endmodule
